/* include/eiu_pkg.sv */
// package for the edge interrupt unit: register map, field layout, resets
// assumes an AXI4-Lite master with 32-bit data and one clock domain
`default_nettype none
package eiu_pkg;
  localparam int unsigned NUM_LINES  = 20;
  localparam int unsigned NUM_PINS   = 16;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  // line index of the supply monitor and other internal sources
  localparam int unsigned LINE_SVM   = 16;
  localparam int unsigned LINE_CAL   = 17;
  localparam int unsigned LINE_TAMP  = 18;
  localparam int unsigned LINE_CMP   = 19;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RISE    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FALL    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PEND    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SWTRIG  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SVMCTL  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LEVEL   = 8'h18;
  // supply monitor control fields
  localparam int unsigned SVM_EN_BIT  = 0;
  localparam int unsigned SVM_DN_BIT  = 1;
  localparam int unsigned SVM_UP_BIT  = 2;
  // reset values
  localparam logic [NUM_LINES-1:0] RST_LINES = 20'h00000;
  localparam logic [2:0]           RST_SVM   = 3'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : eiu_pkg
`default_nettype wire

/* rtl/eiu_sync.sv */
// two-flop synchroniser bank for asynchronous inputs
// assumes a single clock; first stage is read only by the second
`default_nettype none
module eiu_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_o = sync_ff;
endmodule : eiu_sync
`default_nettype wire

/* rtl/eiu_edge.sv */
// one edge detector line: rising, falling or both edges
// assumes a synchronised input level on the same clock
`default_nettype none
module eiu_edge (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // line
  input  wire logic level_i,
  input  wire logic rise_en_i,
  input  wire logic fall_en_i,
  output logic      event_o
);
  logic prev_ff;
  logic nxt_prev;

  always_comb begin
    nxt_prev = level_i;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  // selected edge counts as the trigger
  assign event_o = (rise_en_i & level_i & ~prev_ff) |
                   (fall_en_i & ~level_i & prev_ff);
endmodule : eiu_edge
`default_nettype wire

/* rtl/eiu_top.sv */
// edge interrupt unit: twenty lines, edge select, mask, pending, axi4-lite
// assumes one clock, synchronous active-low reset, asynchronous sources
`default_nettype none
// Operation
// - Twenty independent edge detector lines each raise a request.
// - Each line selects rising, falling or both edges as trigger.
// - Each line has its own mask so a masked line forwards nothing.
// - A pending register keeps one bit per line of unserviced requests.
// - Sixteen lines come from pins and the rest from internal sources.
// - Line requests go straight to the core irq controller unarbitrated.
// - The supply monitor raises events on down, up or both crossings.
// - The supply monitor gives no events until software enables it.
// - Sources are 16 pins, supply monitor, calendar, tamper and stamp sharing one line, comparator.
// - An event on any unmasked line raises a deep-sleep wakeup.
module eiu_top #(
  parameter int unsigned NUM_LINES = eiu_pkg::NUM_LINES
) (
  // clock and reset
  input  wire logic                        CLK_I,
  input  wire logic                        RESET_N_I,
  // axi4-lite write address
  input  wire logic                        S_AXI_AWVALID_I,
  output logic                             S_AXI_AWREADY_O,
  input  wire logic [eiu_pkg::ADDR_W-1:0]  S_AXI_AWADDR_I,
  // axi4-lite write data
  input  wire logic                        S_AXI_WVALID_I,
  output logic                             S_AXI_WREADY_O,
  input  wire logic [eiu_pkg::DATA_W-1:0]  S_AXI_WDATA_I,
  input  wire logic [3:0]                  S_AXI_WSTRB_I,
  // axi4-lite write response
  output logic                             S_AXI_BVALID_O,
  input  wire logic                        S_AXI_BREADY_I,
  output logic [1:0]                       S_AXI_BRESP_O,
  // axi4-lite read address
  input  wire logic                        S_AXI_ARVALID_I,
  output logic                             S_AXI_ARREADY_O,
  input  wire logic [eiu_pkg::ADDR_W-1:0]  S_AXI_ARADDR_I,
  // axi4-lite read data
  output logic                             S_AXI_RVALID_O,
  input  wire logic                        S_AXI_RREADY_I,
  output logic [eiu_pkg::DATA_W-1:0]       S_AXI_RDATA_O,
  output logic [1:0]                       S_AXI_RRESP_O,
  // sources
  input  wire logic [eiu_pkg::NUM_PINS-1:0] PIN_I,
  input  wire logic                        SVM_BELOW_I,
  input  wire logic                        CAL_ALARM_I,
  input  wire logic                        CAL_TAMPER_I,
  input  wire logic                        CAL_STAMP_I,
  input  wire logic                        CMP_WAKE_I,
  // requests
  output logic [NUM_LINES-1:0]             IRQ_LINE_O,
  output logic                             IRQ_O,
  output logic                             WAKEUP_O
);
  localparam int unsigned NS = 5;

  logic [NUM_LINES-1:0] mask_ff, nxt_mask;
  logic [NUM_LINES-1:0] rise_ff, nxt_rise;
  logic [NUM_LINES-1:0] fall_ff, nxt_fall;
  logic [NUM_LINES-1:0] pend_ff, nxt_pend;
  logic [NUM_LINES-1:0] irq_ff, nxt_irq;
  logic                 any_ff, nxt_any;
  logic                 wake_ff, nxt_wake;
  logic [2:0]           svm_ff, nxt_svm;
  logic [NUM_LINES-1:0] swtrig;
  logic [NUM_LINES-1:0] level;
  logic [NUM_LINES-1:0] edge_evt;
  logic [NUM_LINES-1:0] line_rise;
  logic [NUM_LINES-1:0] line_fall;
  logic [NS-1:0]        int_async;
  logic [NS-1:0]        int_sync;
  logic [eiu_pkg::NUM_PINS-1:0] pin_sync;

  // axi state
  logic                        aw_ff, nxt_aw;
  logic                        w_ff, nxt_w;
  logic [eiu_pkg::ADDR_W-1:0]  awaddr_ff, nxt_awaddr;
  logic [eiu_pkg::DATA_W-1:0]  wdata_ff, nxt_wdata;
  logic [3:0]                  wstrb_ff, nxt_wstrb;
  logic                        bvalid_ff, nxt_bvalid;
  logic [1:0]                  bresp_ff, nxt_bresp;
  logic                        rvalid_ff, nxt_rvalid;
  logic [eiu_pkg::DATA_W-1:0]  rdata_ff, nxt_rdata;
  logic [1:0]                  rresp_ff, nxt_rresp;
  logic                        awrdy_ff, nxt_awrdy;
  logic                        wrdy_ff, nxt_wrdy;
  logic                        arrdy_ff, nxt_arrdy;
  logic                        do_wr;
  logic [eiu_pkg::DATA_W-1:0]  wmask;

  function automatic logic addr_ok(input logic [eiu_pkg::ADDR_W-1:0] a);
    addr_ok = (a == eiu_pkg::OFS_MASK) || (a == eiu_pkg::OFS_RISE) ||
              (a == eiu_pkg::OFS_FALL) || (a == eiu_pkg::OFS_PEND) ||
              (a == eiu_pkg::OFS_SWTRIG) || (a == eiu_pkg::OFS_SVMCTL) ||
              (a == eiu_pkg::OFS_LEVEL);
  endfunction : addr_ok

  // pins and internal sources, all synchronised
  eiu_sync #(.WIDTH(eiu_pkg::NUM_PINS)) u_pin_sync (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .async_i   (PIN_I),
    .sync_o    (pin_sync)
  );

  assign int_async = {CMP_WAKE_I, CAL_STAMP_I, CAL_TAMPER_I,
                      CAL_ALARM_I, SVM_BELOW_I};

  eiu_sync #(.WIDTH(NS)) u_int_sync (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .async_i   (int_async),
    .sync_o    (int_sync)
  );

  // line source map
  always_comb begin
    level = '0;
    level[eiu_pkg::NUM_PINS-1:0] = pin_sync;
    level[eiu_pkg::LINE_SVM]  = int_sync[0] & svm_ff[eiu_pkg::SVM_EN_BIT];
    level[eiu_pkg::LINE_CAL]  = int_sync[1];
    level[eiu_pkg::LINE_TAMP] = int_sync[2] | int_sync[3];
    level[eiu_pkg::LINE_CMP]  = int_sync[4];
  end

  // supply monitor follows its own crossing selects when enabled
  always_comb begin
    line_rise = rise_ff;
    line_fall = fall_ff;
    line_rise[eiu_pkg::LINE_SVM] = svm_ff[eiu_pkg::SVM_EN_BIT] &
                                   svm_ff[eiu_pkg::SVM_DN_BIT];
    line_fall[eiu_pkg::LINE_SVM] = svm_ff[eiu_pkg::SVM_EN_BIT] &
                                   svm_ff[eiu_pkg::SVM_UP_BIT];
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      eiu_edge u_edge (
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .level_i   (level[gi]),
        .rise_en_i (line_rise[gi]),
        .fall_en_i (line_fall[gi]),
        .event_o   (edge_evt[gi])
      );
    end
  endgenerate

  // axi write handshake
  assign do_wr = aw_ff && w_ff && !bvalid_ff;
  always_comb begin
    wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
             {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  end

  always_comb begin
    nxt_aw     = aw_ff;
    nxt_w      = w_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    if (S_AXI_AWVALID_I && !aw_ff) begin
      nxt_aw     = 1'b1;
      nxt_awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && !w_ff) begin
      nxt_w     = 1'b1;
      nxt_wdata = S_AXI_WDATA_I;
      nxt_wstrb = S_AXI_WSTRB_I;
    end
    if (do_wr) begin
      nxt_aw     = 1'b0;
      nxt_w      = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = addr_ok(awaddr_ff) ? eiu_pkg::RESP_OKAY
                                      : eiu_pkg::RESP_SLVERR;
    end
    if (bvalid_ff && S_AXI_BREADY_I) begin
      nxt_bvalid = 1'b0;
    end
  end

  // register writes and pending logic
  always_comb begin
    nxt_mask = mask_ff;
    nxt_rise = rise_ff;
    nxt_fall = fall_ff;
    nxt_svm  = svm_ff;
    swtrig   = '0;
    nxt_pend = pend_ff;
    if (do_wr) begin
      case (awaddr_ff)
        eiu_pkg::OFS_MASK:
          nxt_mask = (mask_ff & ~wmask[NUM_LINES-1:0]) |
                     (wdata_ff[NUM_LINES-1:0] & wmask[NUM_LINES-1:0]);
        eiu_pkg::OFS_RISE:
          nxt_rise = (rise_ff & ~wmask[NUM_LINES-1:0]) |
                     (wdata_ff[NUM_LINES-1:0] & wmask[NUM_LINES-1:0]);
        eiu_pkg::OFS_FALL:
          nxt_fall = (fall_ff & ~wmask[NUM_LINES-1:0]) |
                     (wdata_ff[NUM_LINES-1:0] & wmask[NUM_LINES-1:0]);
        eiu_pkg::OFS_PEND:
          nxt_pend = pend_ff &
                     ~(wdata_ff[NUM_LINES-1:0] & wmask[NUM_LINES-1:0]);
        eiu_pkg::OFS_SWTRIG:
          swtrig = wdata_ff[NUM_LINES-1:0] & wmask[NUM_LINES-1:0];
        eiu_pkg::OFS_SVMCTL:
          if (wstrb_ff[0]) begin
            nxt_svm = wdata_ff[2:0];
          end
        default: begin
        end
      endcase
    end
    // set wins over clear
    nxt_pend = nxt_pend | edge_evt | swtrig;
    nxt_irq  = nxt_pend & mask_ff;
    nxt_any  = |(nxt_pend & mask_ff);
    nxt_wake = |(edge_evt & mask_ff);
  end

  // axi read
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (S_AXI_ARVALID_I && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = addr_ok(S_AXI_ARADDR_I) ? eiu_pkg::RESP_OKAY
                                           : eiu_pkg::RESP_SLVERR;
      nxt_rdata  = '0;
      case (S_AXI_ARADDR_I)
        eiu_pkg::OFS_MASK:   nxt_rdata[NUM_LINES-1:0] = mask_ff;
        eiu_pkg::OFS_RISE:   nxt_rdata[NUM_LINES-1:0] = rise_ff;
        eiu_pkg::OFS_FALL:   nxt_rdata[NUM_LINES-1:0] = fall_ff;
        eiu_pkg::OFS_PEND:   nxt_rdata[NUM_LINES-1:0] = pend_ff;
        eiu_pkg::OFS_SVMCTL: nxt_rdata[2:0] = svm_ff;
        eiu_pkg::OFS_LEVEL:  nxt_rdata[NUM_LINES-1:0] = level;
        default: begin
        end
      endcase
    end else if (rvalid_ff && S_AXI_RREADY_I) begin
      nxt_rvalid = 1'b0;
    end
  end

  // readies registered so every output leaves a flop
  always_comb begin
    nxt_awrdy = ~nxt_aw;
    nxt_wrdy  = ~nxt_w;
    nxt_arrdy = ~nxt_rvalid;
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      mask_ff   <= eiu_pkg::RST_LINES;
      rise_ff   <= eiu_pkg::RST_LINES;
      fall_ff   <= eiu_pkg::RST_LINES;
      pend_ff   <= eiu_pkg::RST_LINES;
      irq_ff    <= eiu_pkg::RST_LINES;
      any_ff    <= 1'b0;
      wake_ff   <= 1'b0;
      svm_ff    <= eiu_pkg::RST_SVM;
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= eiu_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= eiu_pkg::RESP_OKAY;
      awrdy_ff  <= 1'b1;
      wrdy_ff   <= 1'b1;
      arrdy_ff  <= 1'b1;
    end else begin
      mask_ff   <= nxt_mask;
      rise_ff   <= nxt_rise;
      fall_ff   <= nxt_fall;
      pend_ff   <= nxt_pend;
      irq_ff    <= nxt_irq;
      any_ff    <= nxt_any;
      wake_ff   <= nxt_wake;
      svm_ff    <= nxt_svm;
      aw_ff     <= nxt_aw;
      w_ff      <= nxt_w;
      awaddr_ff <= nxt_awaddr;
      wdata_ff  <= nxt_wdata;
      wstrb_ff  <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
      awrdy_ff  <= nxt_awrdy;
      wrdy_ff   <= nxt_wrdy;
      arrdy_ff  <= nxt_arrdy;
    end
  end

  // outputs
  assign S_AXI_AWREADY_O = awrdy_ff;
  assign S_AXI_WREADY_O  = wrdy_ff;
  assign S_AXI_BVALID_O  = bvalid_ff;
  assign S_AXI_BRESP_O   = bresp_ff;
  assign S_AXI_ARREADY_O = arrdy_ff;
  assign S_AXI_RVALID_O  = rvalid_ff;
  assign S_AXI_RDATA_O   = rdata_ff;
  assign S_AXI_RRESP_O   = rresp_ff;
  assign IRQ_LINE_O      = irq_ff;
  assign IRQ_O           = any_ff;
  assign WAKEUP_O        = wake_ff;
endmodule : eiu_top
`default_nettype wire

/* verification/eiu_src_model.sv */
// far-side model: pin levels and internal event sources
// assumes the bench calls set_src; levels move after a rising edge
`default_nettype none
module eiu_src_model (
  // clock
  input  wire logic        clk_i,
  // sources
  output logic      [15:0] pin_o,
  output logic             svm_o,
  output logic             alarm_o,
  output logic             tamper_o,
  output logic             stamp_o,
  output logic             cmp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [20:0] lvl_ff = 21'h000000;
  // pins, supply, calendar, tamper, stamp, comparator
  assign {cmp_o, stamp_o, tamper_o, alarm_o, svm_o, pin_o} = lvl_ff;
  task automatic set_src(input logic [20:0] v);
    @(posedge clk_i);
    lvl_ff <= v;
  endtask : set_src
endmodule : eiu_src_model
`default_nettype wire

/* verification/eiu_top_assertions.sv */
// port assertions for the edge interrupt unit
// assumes a bind onto eiu_top, one clock domain
`default_nettype none
module eiu_top_assertions #(
  parameter int unsigned NUM_LINES = eiu_pkg::NUM_LINES
) (
  // clock and reset
  input wire logic                 CLK_I,
  input wire logic                 RESET_N_I,
  // bus
  input wire logic                 S_AXI_AWVALID_I,
  input wire logic                 S_AXI_AWREADY_O,
  input wire logic                 S_AXI_WVALID_I,
  input wire logic                 S_AXI_WREADY_O,
  input wire logic                 S_AXI_BVALID_O,
  input wire logic                 S_AXI_BREADY_I,
  input wire logic                 S_AXI_ARVALID_I,
  input wire logic                 S_AXI_ARREADY_O,
  input wire logic                 S_AXI_RVALID_O,
  // requests
  input wire logic [NUM_LINES-1:0] IRQ_LINE_O,
  input wire logic                 IRQ_O,
  input wire logic                 WAKEUP_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_wr_taken;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  sequence s_rd_taken;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  endsequence
  property p_wr_resp; s_wr_taken |-> ##[1:2] S_AXI_BVALID_O; endproperty
  property p_wr_refuse;
    s_wr_taken |=> !S_AXI_AWREADY_O && !S_AXI_WREADY_O;
  endproperty
  property p_rd_lat; s_rd_taken |=> S_AXI_RVALID_O; endproperty
  property p_rd_refuse; S_AXI_RVALID_O |-> !S_AXI_ARREADY_O; endproperty
  property p_b_done;
    S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O;
  endproperty
  property p_reset;
    disable iff (1'b0)
    !RESET_N_I |=> !IRQ_O && IRQ_LINE_O == '0 && !S_AXI_BVALID_O;
  endproperty
  property p_irq_any; IRQ_O == (|IRQ_LINE_O); endproperty
  property p_sticky;
    (|($past(IRQ_LINE_O) & ~IRQ_LINE_O)) |->
      S_AXI_BVALID_O || $past(S_AXI_BVALID_O);
  endproperty
  property p_wake; WAKEUP_O |-> IRQ_O; endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response missing");
  a_wr_refuse: assert property (p_wr_refuse)
    else $error("write channel ready after accept");
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data late");
  a_rd_refuse: assert property (p_rd_refuse)
    else $error("read address ready while data pending");
  a_b_done: assert property (p_b_done)
    else $error("write response repeated");
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
  a_irq_any: assert property (p_irq_any)
    else $error("summary request differs from lines");
  a_sticky: assert property (p_sticky)
    else $error("line request dropped without a write");
  a_wake: assert property (p_wake)
    else $error("wakeup without request");
endmodule : eiu_top_assertions
bind eiu_top eiu_top_assertions #(.NUM_LINES(NUM_LINES))
  eiu_top_assertions_inst (.*);
`default_nettype wire

/* verification/eiu_top_bench.sv */
// self-checking bench for the edge interrupt unit over axi4-lite
// assumes eiu_src_model drives the sources, one 200 MHz clock
`default_nettype none
module eiu_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] pend = eiu_pkg::OFS_PEND;
  localparam logic [7:0] mask = eiu_pkg::OFS_MASK;
  localparam logic [1:0] ok   = eiu_pkg::RESP_OKAY;
  localparam logic [1:0] er   = eiu_pkg::RESP_SLVERR;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [3:0]  wst = 4'h0;
  logic        awr, wrdy, bv, arr, rv, svm, alm, tmp, stp, cmpw, wake, irq;
  logic [1:0]  bresp, rresp;
  logic [15:0] pin;
  logic [19:0] irql;
  logic [2:0]  ctl [4] = '{3'h0, 3'h3, 3'h5, 3'h7};
  int          bad_count = 0;
  int          checked = 0;
  int          wake_n = 0;
  always #2.5 clk = ~clk;
  // wakeup pulses counted where they are settled
  always @(negedge clk) if (wake === 1'b1) wake_n++;
  eiu_top eiu_top_inst (
    .CLK_I(clk), .RESET_N_I(rst_n),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wdat),
    .S_AXI_WSTRB_I(wst), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(brdy),
    .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rrdy),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp), .PIN_I(pin),
    .SVM_BELOW_I(svm), .CAL_ALARM_I(alm), .CAL_TAMPER_I(tmp),
    .CAL_STAMP_I(stp), .CMP_WAKE_I(cmpw), .IRQ_LINE_O(irql),
    .IRQ_O(irq), .WAKEUP_O(wake));
  eiu_src_model eiu_src_model_inst (
    .clk_i(clk), .pin_o(pin), .svm_o(svm), .alarm_o(alm),
    .tamper_o(tmp), .stamp_o(stp), .cmp_o(cmpw));
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] e);
    logic pa, pw, ta, tw;
    int   n;
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wdat <= d;
    wst <= s;
    while ((pa || pw) && n < 50) begin
      @(negedge clk);
      n++;
      ta = pa && awr === 1'b1;
      tw = pw && wrdy === 1'b1;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    brdy <= 1'b1;
    do @(negedge clk); while (bv !== 1'b1 && ++n < 50);
    check("bvalid", 32'(bv), 32'h1);
    check("bresp", 32'(bresp), 32'(e));
    @(posedge clk);
    brdy <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] x);
    int n;
    n = 0;
    arv <= 1'b1;
    ara <= a;
    do @(negedge clk); while (arr !== 1'b1 && ++n < 50);
    @(posedge clk);
    arv <= 1'b0;
    rrdy <= 1'b1;
    do @(negedge clk); while (rv !== 1'b1 && ++n < 50);
    check("rvalid", 32'(rv), 32'h1);
    check($sformatf("rdata %h", a), rdat, e);
    check("rresp", 32'(rresp), 32'(x));
    @(posedge clk);
    rrdy <= 1'b0;
  endtask : rdc
  task automatic clr();
    wr(pend, 32'hffffffff, 4'hf, ok);
  endtask : clr
  task automatic src(input logic [20:0] v);
    eiu_src_model_inst.set_src(v);
    repeat (6) @(posedge clk);
  endtask : src
  initial begin
    #100us;
    bad_count++;
    summarize();
  end
  initial begin
    logic [31:0] rs, fl;
    rs = 32'h000e0000;
    fl = 32'h0;
    for (int k = 0; k < 16; k++) begin
      rs[k] = (k % 3 != 1);
      fl[k] = (k % 3 != 0);
    end
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rdc(8'(4 * i), 32'h0, ok);
    rdc(8'h40, 32'h0, er);
    wr(8'h40, 32'h1, 4'hf, er);
    $display("test reset and map done");
    wr(mask, 32'h000fffff, 4'hf, ok);
    wr(eiu_pkg::OFS_RISE, rs, 4'hf, ok);
    wr(eiu_pkg::OFS_FALL, fl, 4'hf, ok);
    src(21'h00ffff);
    rdc(pend, rs & 32'hffff, ok);
    check("irq lines", 32'(irql), rs & 32'hffff);
    check("irq", 32'(irq), 32'h1);
    rdc(eiu_pkg::OFS_LEVEL, 32'hffff, ok);
    check("wake count", 32'(wake_n), 32'h1);
    wr(pend, 32'h1, 4'hf, ok);
    rdc(pend, rs & 32'hfffe, ok);
    clr();
    check("irq", 32'(irq), 32'h0);
    src(21'h0);
    rdc(pend, fl & 32'hffff, ok);
    clr();
    $display("test edges done");
    wr(mask, 32'h0000000f, 4'hf, ok);
    src(21'h00ffff);
    rdc(pend, rs & 32'hffff, ok);
    check("irq lines", 32'(irql), rs & 32'hf);
    wr(mask, 32'hffffffff, 4'h5, ok);
    rdc(mask, 32'h000f00ff, ok);
    wr(mask, 32'h000fffff, 4'hf, ok);
    clr();
    src(21'h0);
    clr();
    $display("test mask done");
    for (int j = 0; j < 4; j++) begin
      src(21'h1 << (17 + j));
      rdc(pend, 32'h1 << (17 + (j > 0) + (j > 2)), ok);
      clr();
      src(21'h0);
      rdc(pend, 32'h0, ok);
    end
    $display("test internal lines done");
    for (int s = 0; s < 8; s++) begin
      if (s % 2 == 0) wr(eiu_pkg::OFS_SVMCTL, 32'(ctl[s / 2]), 4'hf, ok);
      src(21'(s % 2 == 0) << 16);
      rdc(pend, 32'(s == 2 || s > 4) << 16, ok);
      clr();
    end
    $display("test supply monitor done");
    wr(eiu_pkg::OFS_SWTRIG, 32'h20, 4'hf, ok);
    rdc(pend, 32'h20, ok);
    rdc(eiu_pkg::OFS_SWTRIG, 32'h0, ok);
    check("wake count", 32'(wake_n), 32'hc);
    clr();
    $display("test software trigger done");
    summarize();
  end
endmodule : eiu_top_bench
`default_nettype wire
